/* design/otcm_pkg.sv */
// package for the oscillator trim and clock multiplier block.
// assumes a single 40 MHz sys_clk and an 8-bit register port.
package otcm_pkg;
  localparam logic [7:0] MULT_CTRL_ADDR   = 8'h97;
  localparam logic [7:0] FINE_TRIM_ADDR   = 8'h9E;
  localparam logic [7:0] COARSE_TRIM_ADDR = 8'hA2;

  localparam int MULT_ON_BIT    = 7;
  localparam int MULT_INIT_BIT  = 6;
  localparam int MULT_LOCK_BIT  = 5;
  localparam int SCALE_LSB      = 2;
  localparam int SOURCE_LSB     = 0;
  localparam int COARSE_W       = 7;
  localparam int FINE_W         = 6;

  localparam logic [7:0] MULT_CTRL_RESET = 8'h00;

  localparam logic [1:0] SRC_INT_HALF = 2'h0;
  localparam logic [1:0] SRC_EXT      = 2'h1;
  localparam logic [1:0] SRC_EXT_HALF = 2'h2;
  localparam logic [1:0] CORE_SEL_MULT = 2'h2;

  localparam logic [2:0] SCALE_FIRST_FRAC = 3'h3;
  localparam logic [2:0] SCALE_UNITY_DIV  = 3'h2;

  // ticks are half periods of the x4 clock: eight per input period
  localparam logic [3:0] TICKS_PER_INPUT = 4'h8;
  localparam int         TICK_SHIFT      = 3;

  localparam int CLK_PERIOD_NS  = 25;
  localparam int LOCK_TIME_NS   = 2000;
  localparam int LOCK_CYCLES    = (LOCK_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FAST_GAP_NS    = 100;
  localparam int FAST_GAP_CYC   = FAST_GAP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OTCM_OFF,
    OTCM_WARM,
    OTCM_LOCKING,
    OTCM_LOCKED
  } otcm_state_t;
endpackage

/* design/otcm_src_sel.sv */
// input conditioning for the multiplier: synchronises both oscillator
// pins, halves them and picks one source as a rising-edge pulse.
// assumes oscillator pins are well below half of sys_clk.
`timescale 1ns/1ps
module otcm_src_sel
  import otcm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       int_osc_clk,
  input  wire logic       ext_osc_clk,
  input  wire logic [1:0] source,
  output logic            src_rise
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] last_reg;
  logic [1:0] half_reg;
  logic [1:0] rise;
  logic       sel_next;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_pin
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          last_reg[i] <= 1'b0;
          half_reg[i] <= 1'b0;
        end
        else
        begin
          meta_reg[i] <= (i == 0) ? int_osc_clk : ext_osc_clk;
          sync_reg[i] <= meta_reg[i];
          last_reg[i] <= sync_reg[i];
          if (rise[i])
            half_reg[i] <= ~half_reg[i];
        end
      end
      assign rise[i] = sync_reg[i] & ~last_reg[i];
    end
  endgenerate

  // reserved code 11 falls back to the halved external path
  always_comb
  begin
    unique case (source)
      SRC_INT_HALF: sel_next = rise[0] & ~half_reg[0];
      SRC_EXT:      sel_next = rise[1];
      default:      sel_next = rise[1] & ~half_reg[1];
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      src_rise <= 1'b0;
    else
      src_rise <= sel_next;
  end
endmodule

/* design/otcm_top.sv */
// oscillator trim registers and a digital model of the clock multiplier.
// assumes one sys_clk; oscillator pins arrive asynchronously and the
// analog oscillator consumes the trim outputs directly.
`timescale 1ns/1ps
module otcm_top
  import otcm_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic [7:0]          addr,
  input  wire logic [7:0]          wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [7:0]          rd_data,
  input  wire logic                int_osc_clk,
  input  wire logic                ext_osc_clk,
  input  wire logic [COARSE_W-1:0] factory_coarse,
  input  wire logic [FINE_W-1:0]   factory_fine,
  input  wire logic [1:0]          core_clock_source,
  output logic      [COARSE_W-1:0] coarse_trim,
  output logic      [FINE_W-1:0]   fine_trim,
  output logic                     mult_clk,
  output logic                     mult_locked,
  output logic                     core_from_mult
);
  otcm_state_t state_reg;
  otcm_state_t state_next;

  logic        cal_pending_reg;
  logic        mult_on_reg;
  logic        mult_init_reg;
  logic [2:0]  scale_reg;
  logic [1:0]  source_reg;
  logic [15:0] lock_cnt_reg;
  logic [15:0] period_cnt_reg;
  logic [15:0] gap_reg;
  logic [15:0] gap_cnt_reg;
  logic [3:0]  burst_reg;
  logic [2:0]  scale_cnt_reg;
  logic [2:0]  divisor;
  logic [2:0]  half;
  logic [15:0] gap_next;
  logic        src_rise;
  logic        tick;
  logic        running;
  logic        wr_ctrl;
  logic        ctrl_off;
  logic        init_req;
  logic [7:0]  rd_next;

  assign wr_ctrl  = wr_en && (addr == MULT_CTRL_ADDR);
  assign ctrl_off = wr_ctrl && !wr_data[MULT_ON_BIT];
  assign init_req = wr_ctrl && wr_data[MULT_ON_BIT]
                    && wr_data[MULT_INIT_BIT];
  assign running  = (state_reg != OTCM_OFF);

  // trim fields; calibration straps are taken one edge after release
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cal_pending_reg <= 1'b1;
      coarse_trim     <= '0;
      fine_trim       <= '0;
    end
    else if (cal_pending_reg)
    begin
      cal_pending_reg <= 1'b0;
      coarse_trim     <= factory_coarse;
      fine_trim       <= factory_fine;
    end
    else if (wr_en)
    begin
      // upper bits are dropped, the oscillator sees only the field
      if (addr == COARSE_TRIM_ADDR)
        coarse_trim <= wr_data[COARSE_W-1:0];
      if (addr == FINE_TRIM_ADDR)
        fine_trim <= wr_data[FINE_W-1:0];
    end
  end

  // control fields; a zero write clears everything at once
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mult_on_reg   <= MULT_CTRL_RESET[MULT_ON_BIT];
      mult_init_reg <= MULT_CTRL_RESET[MULT_INIT_BIT];
      scale_reg     <= MULT_CTRL_RESET[SCALE_LSB+:3];
      source_reg    <= MULT_CTRL_RESET[SOURCE_LSB+:2];
    end
    else if (wr_ctrl)
    begin
      mult_on_reg   <= wr_data[MULT_ON_BIT];
      mult_init_reg <= wr_data[MULT_INIT_BIT];
      scale_reg     <= wr_data[SCALE_LSB+:3];
      source_reg    <= wr_data[SOURCE_LSB+:2];
    end
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      OTCM_OFF:
        if (wr_ctrl && wr_data[MULT_ON_BIT])
          state_next = init_req ? OTCM_LOCKING : OTCM_WARM;
      OTCM_WARM:
        if (init_req)
          state_next = OTCM_LOCKING;
      OTCM_LOCKING:
        if (lock_cnt_reg == 16'(LOCK_CYCLES - 1))
          state_next = OTCM_LOCKED;
      OTCM_LOCKED:
        if (init_req)
          state_next = OTCM_LOCKING;
    endcase
    if (ctrl_off)
      state_next = OTCM_OFF;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_reg <= OTCM_OFF;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      lock_cnt_reg <= '0;
    else if (state_reg != OTCM_LOCKING || init_req)
      lock_cnt_reg <= '0;
    else
      lock_cnt_reg <= lock_cnt_reg + 16'h0001;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      mult_locked <= 1'b0;
    else
      mult_locked <= (state_next == OTCM_LOCKED);
  end

  otcm_src_sel u_src_sel (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .int_osc_clk (int_osc_clk),
    .ext_osc_clk (ext_osc_clk),
    .source      (source_reg),
    .src_rise    (src_rise)
  );

  // input period, saturating so a stopped source cannot wrap
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      period_cnt_reg <= '0;
    else if (src_rise)
      period_cnt_reg <= 16'h0001;
    else if (period_cnt_reg != 16'hFFFF)
      period_cnt_reg <= period_cnt_reg + 16'h0001;
  end

  // tick spacing: an eighth of the period, but never slower than the
  // fastest lock rate, so a slow input gets a quick burst then idles
  always_comb
  begin
    gap_next = period_cnt_reg >> TICK_SHIFT;
    if (gap_next > 16'(FAST_GAP_CYC))
      gap_next = 16'(FAST_GAP_CYC);
    if (gap_next == 16'h0000)
      gap_next = 16'h0001;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      gap_reg     <= 16'h0001;
      gap_cnt_reg <= 16'h0001;
      burst_reg   <= '0;
    end
    else if (!running)
    begin
      gap_cnt_reg <= 16'h0001;
      burst_reg   <= '0;
    end
    else if (src_rise)
    begin
      // every input edge restarts a full burst of ticks
      gap_reg     <= gap_next;
      gap_cnt_reg <= gap_next;
      burst_reg   <= TICKS_PER_INPUT;
    end
    else if (burst_reg != 4'h0)
    begin
      if (gap_cnt_reg <= 16'h0001)
      begin
        gap_cnt_reg <= gap_reg;
        burst_reg   <= burst_reg - 4'h1;
      end
      else
        gap_cnt_reg <= gap_cnt_reg - 16'h0001;
    end
  end

  assign tick = running && !src_rise && (burst_reg != 4'h0)
                && (gap_cnt_reg <= 16'h0001);

  // divisor d gives 2/d; codes below the first fraction mean unity
  assign divisor = (scale_reg < SCALE_FIRST_FRAC) ? SCALE_UNITY_DIV
                                                  : scale_reg;
  assign half    = divisor >> 1;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      scale_cnt_reg <= '0;
    else if (!running)
      scale_cnt_reg <= '0;
    else if (tick)
      scale_cnt_reg <= (scale_cnt_reg >= divisor - 3'h1) ? 3'h0
                       : scale_cnt_reg + 3'h1;
  end

  // odd divisors stay high for the shorter half, so duty is uneven
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      mult_clk <= 1'b0;
    else if (!running)
      mult_clk <= 1'b0;
    else
      mult_clk <= (scale_cnt_reg < half);
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      core_from_mult <= 1'b0;
    else
      core_from_mult <= (core_clock_source == CORE_SEL_MULT);
  end

  always_comb
  begin
    rd_next = 8'h00;
    unique case (addr)
      MULT_CTRL_ADDR:
        rd_next = {mult_on_reg, mult_init_reg, mult_locked,
                   scale_reg, source_reg};
      FINE_TRIM_ADDR:   rd_next = {2'h0, fine_trim};
      COARSE_TRIM_ADDR: rd_next = {1'h0, coarse_trim};
      default:          rd_next = 8'h00;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= rd_next;
    else
      rd_data <= 8'h00;
  end

  localparam int LOCK_MAX = LOCK_CYCLES + 2;

  // cycles since the last initialise with no control write since; a
  // counter keeps the lock window out of a long repetition
  logic [7:0] since_init_reg;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      since_init_reg <= 8'h00;
    else if (init_req)
      since_init_reg <= 8'h01;
    else if (wr_ctrl)
      since_init_reg <= 8'h00;
    else if (since_init_reg != 8'h00 && since_init_reg != 8'hFF)
      since_init_reg <= since_init_reg + 8'h01;
  end

  coarse_write_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    wr_en && addr == COARSE_TRIM_ADDR && !cal_pending_reg
    |=> coarse_trim == $past(wr_data[COARSE_W-1:0]))
    else $error("coarse trim did not take the write");

  fine_write_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    wr_en && addr == FINE_TRIM_ADDR && !cal_pending_reg
    |=> fine_trim == $past(wr_data[FINE_W-1:0]))
    else $error("fine trim did not take the write");

  cal_load_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    cal_pending_reg |=> coarse_trim == $past(factory_coarse)
                        && fine_trim == $past(factory_fine))
    else $error("factory calibration not loaded");

  unused_zero_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    rd_en && (addr == FINE_TRIM_ADDR || addr == COARSE_TRIM_ADDR)
    |=> rd_data[7] == 1'b0
        && ($past(addr) != FINE_TRIM_ADDR || !rd_data[6]))
    else $error("unused trim bits read nonzero");

  off_drops_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    ctrl_off |=> !mult_locked ##1 !mult_locked && !mult_clk)
    else $error("disable did not stop the multiplier");

  lock_time_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    init_req && !ctrl_off |=> !mult_locked [*8])
    else $error("locked flag rose too early");

  lock_reach_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    since_init_reg == 8'(LOCK_MAX) && !wr_ctrl |-> mult_locked)
    else $error("multiplier never locked");

  burst_len_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    running && src_rise |=> burst_reg == TICKS_PER_INPUT
                            && gap_cnt_reg <= 16'(FAST_GAP_CYC))
    else $error("input edge did not restart a burst");

  scale_range_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    scale_cnt_reg < divisor || $changed(scale_reg))
    else $error("scale counter out of range");

  core_sel_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    core_clock_source == CORE_SEL_MULT |=> core_from_mult)
    else $error("multiplier not offered to core clock");

  locked_c: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(mult_locked));
  frac_c: cover property (@(posedge sys_clk) disable iff (reset)
    mult_locked && scale_reg == 3'h7 && tick);
  int_src_c: cover property (@(posedge sys_clk) disable iff (reset)
    source_reg == SRC_INT_HALF && src_rise && running);
  relock_c: cover property (@(posedge sys_clk) disable iff (reset)
    state_reg == OTCM_LOCKED && init_req);
endmodule

/* tb/otcm_top_test.sv */
// self-checking bench for otcm_top: trims, control register, lock, clock.
// assumes slow oscillator pins made here and a 40 MHz sys_clk.
`timescale 1ns/1ps
module otcm_top_test;
  import otcm_pkg::*;
  localparam logic [6:0] FC = 7'h5A;
  localparam logic [5:0] FF = 6'h2B;
  localparam int         W  = 1536;
  logic                sys_clk;
  logic                reset;
  logic                wr_en;
  logic                rd_en;
  logic                int_osc_clk;
  logic                ext_osc_clk;
  logic [7:0]          addr;
  logic [7:0]          wr_data;
  logic [7:0]          rd_data;
  logic [1:0]          core_clock_source;
  logic [COARSE_W-1:0] coarse_trim;
  logic [FINE_W-1:0]   fine_trim;
  logic                mult_clk;
  logic                mult_locked;
  logic                core_from_mult;
  int                  fail_count = 0;
  int                  cmp_count = 0;
  int                  cyc = 0;
  int                  n;

  otcm_top dut (
    .sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .int_osc_clk(int_osc_clk), .ext_osc_clk(ext_osc_clk),
    .factory_coarse(FC), .factory_fine(FF),
    .core_clock_source(core_clock_source), .coarse_trim(coarse_trim),
    .fine_trim(fine_trim), .mult_clk(mult_clk),
    .mult_locked(mult_locked), .core_from_mult(core_from_mult)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // both oscillators run from time zero, so they are stable at init
  initial
  begin
    ext_osc_clk = 1'b0;
    forever #800 ext_osc_clk = ~ext_osc_clk;
  end

  initial
  begin
    int_osc_clk = 1'b0;
    forever #820 int_osc_clk = ~int_osc_clk;
  end

  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      finish_test;
    end
  end

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_near(input string what, input int exp,
                            input int got, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol)
    begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    check(what, exp, rd_data);
  endtask

  task automatic start_mult(input logic [1:0] src, input logic [2:0] sc);
    logic [7:0] cfg;
    cfg = {3'h0, sc, src};
    reg_wr(MULT_CTRL_ADDR, 8'h00);
    reg_wr(MULT_CTRL_ADDR, cfg);
    reg_wr(MULT_CTRL_ADDR, cfg | 8'h80);
    // 201 cycles is just over the 5 us settling wait
    repeat (201) @(posedge sys_clk);
    reg_wr(MULT_CTRL_ADDR, cfg | 8'hC0);
    // n counts edges after the taking edge; the flag shows on edge n
    n = 0;
    while (mult_locked !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check_near("lock delay", LOCK_CYCLES, n, 1);
    reg_rd(MULT_CTRL_ADDR, cfg | 8'hE0, "ctrl locked");
  endtask

  task automatic count_rises(input int cycles, output int k);
    logic prev;
    prev = mult_clk;
    k = 0;
    repeat (cycles)
    begin
      @(posedge sys_clk);
      #1;
      if (mult_clk === 1'b1 && prev !== 1'b1)
        k++;
      prev = mult_clk;
    end
  endtask

  // rises in the window: input periods times ticks per period over d
  function automatic int rises_exp(input int per_ns, input int tpp,
                                   input int sc);
    int d;
    d = (sc < 3) ? 2 : sc;
    return (W * CLK_PERIOD_NS * tpp) / (per_ns * d);
  endfunction

  initial
  begin
    reset = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    core_clock_source = 2'h0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("coarse out", {1'b0, FC}, {1'b0, coarse_trim});
    check("fine out", {2'h0, FF}, {2'h0, fine_trim});
    reg_rd(COARSE_TRIM_ADDR, {1'b0, FC}, "coarse rd");
    reg_rd(FINE_TRIM_ADDR, {2'h0, FF}, "fine rd");
    reg_rd(MULT_CTRL_ADDR, MULT_CTRL_RESET, "ctrl rd");
    reg_wr(COARSE_TRIM_ADDR, 8'hFF);
    reg_wr(FINE_TRIM_ADDR, 8'hFF);
    reg_rd(COARSE_TRIM_ADDR, 8'h7F, "coarse wr");
    reg_rd(FINE_TRIM_ADDR, 8'h3F, "fine wr");
    reg_wr(COARSE_TRIM_ADDR, 8'h80);
    // a stray decode would leave 0x15 in a trim field
    reg_wr(8'h55, 8'h15);
    reg_rd(8'h55, 8'h00, "unmapped rd");
    check("coarse zero", 8'h00, {1'b0, coarse_trim});
    reg_rd(FINE_TRIM_ADDR, 8'h3F, "fine kept");
    reg_wr(MULT_CTRL_ADDR, 8'h40);
    repeat (100) @(posedge sys_clk);
    #1;
    check("init while off", 8'h00, {7'h0, mult_locked});
    for (int s = 0; s < 3; s += 2)
    begin
      start_mult(s[1:0], 3'h0);
      count_rises(W, n);
      check_near("src rises", rises_exp(s == 0 ? 1640 : 1600, 4, 0),
                 n, 4);
    end
    for (int sc = 0; sc < 8; sc++)
    begin
      start_mult(SRC_EXT, sc[2:0]);
      count_rises(W, n);
      check_near("scale rises", rises_exp(1600, 8, sc),
                 n, 4);
    end
    reg_wr(MULT_CTRL_ADDR, 8'hDD);
    @(posedge sys_clk);
    #1;
    check("reinit lock", 8'h00, {7'h0, mult_locked});
    repeat (LOCK_CYCLES) @(posedge sys_clk);
    #1;
    check("relock", 8'h01, {7'h0, mult_locked});
    reg_wr(MULT_CTRL_ADDR, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    check("off lock", 8'h00, {7'h0, mult_locked});
    count_rises(200, n);
    check_near("off rises", 0, n, 0);
    @(posedge sys_clk);
    core_clock_source <= CORE_SEL_MULT;
    repeat (2) @(posedge sys_clk);
    #1;
    check("core sel", 8'h01, {7'h0, core_from_mult});
    @(posedge sys_clk);
    core_clock_source <= 2'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("core other", 8'h00, {7'h0, core_from_mult});
    @(posedge sys_clk);
    reset <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("coarse in reset", 8'h00, {1'b0, coarse_trim});
    @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check("coarse reload", {1'b0, FC}, {1'b0, coarse_trim});
    check("fine reload", {2'h0, FF}, {2'h0, fine_trim});
    finish_test;
  end
endmodule
